// [design/emp_ext_mem_unit.sv]
// External memory port: arbitration, paged decode, packing, strobes, bus grant.
// Assumes requesters hold req and payload until ack; pins arrive asynchronously.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`default_nettype none
`include "emp_consts.svh"

module emp_ext_mem_unit
	import emp_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core request port
	input  wire logic        core_req,
	input  wire logic        core_we,
	input  wire logic [1:0]  core_space,
	input  wire logic [23:0] core_addr,
	input  wire logic [23:0] core_wdata,
	input  wire logic        core_w24,
	input  wire logic        core_lock,
	output logic             core_ack,
	output logic             core_err,
	output logic [23:0]      core_rdata,
	output logic             core_stall,
	// DMA request port
	input  wire logic        dma_req,
	input  wire logic        dma_we,
	input  wire logic [1:0]  dma_space,
	input  wire logic [23:0] dma_addr,
	input  wire logic [23:0] dma_wdata,
	input  wire logic        dma_w24,
	output logic             dma_ack,
	output logic             dma_err,
	output logic [23:0]      dma_rdata,
	// External bus pins
	output logic [19:0]      ext_addr_o,
	output logic             ext_addr_oe,
	output logic [15:0]      ext_data_o,
	output logic             ext_data_oe,
	input  wire logic [15:0] ext_data_i,
	output logic [3:0]       bank_select_n,
	output logic             io_space_select_n,
	output logic             boot_space_select_n,
	output logic             ext_rd_strobe,
	output logic             ext_wr_strobe,
	output logic             ext_ctl_oe,
	input  wire logic        ext_ready_i,
	// Bus request and grant
	input  wire logic        ext_bus_req_n,
	output logic             ext_bus_grant_n,
	output logic             grant_held_off_n
);

////////////////////////////////////////////////////////////////////////////////
// Registers and pin synchronisers

	logic [`EMP_CFG_W-1:0] cfg_reg [0:5];
	logic [31:0]           bound_reg;
	logic [2:0]            ctrl_reg;

	logic [15:0] data_s1_reg, data_s2_reg;
	logic        rdy_s1_reg, rdy_s2_reg;
	logic        breq_s1_reg, breq_s2_reg;

	always_ff @(posedge aclk)
	begin
		data_s1_reg <= ext_data_i;
		data_s2_reg <= data_s1_reg;
		rdy_s1_reg  <= ext_ready_i;
		rdy_s2_reg  <= rdy_s1_reg;
		// Not reset: the handshake must keep running while reset is held
		breq_s1_reg <= ~ext_bus_req_n;
		breq_s2_reg <= breq_s1_reg;
	end

////////////////////////////////////////////////////////////////////////////////
// Request selection and decode

	emp_mem_st_t mem_st_reg;
	emp_gr_st_t  gr_st_reg;
	logic        lock_reg;

	logic        excl;
	logic        dma_live;
	logic        pick_core;
	logic        pick_dma;
	logic        m_we;
	logic [1:0]  m_space;
	logic [23:0] m_addr;
	logic        m_w24;
	logic [7:0]  page;
	logic [7:0]  io_page;
	logic [2:0]  cfg_idx;
	logic        off_chip;
	logic [3:0]  bank_hot;

	assign excl     = ctrl_reg[`EMP_F_EXCL];
	assign dma_live = dma_req & ~excl;
	assign pick_core = core_req;
	assign pick_dma  = ~core_req & dma_live;
	assign m_we      = pick_core ? core_we : dma_we;
	assign m_space   = pick_core ? core_space : dma_space;
	assign m_addr    = pick_core ? core_addr : dma_addr;
	assign m_w24     = pick_core ? core_w24 : dma_w24;
	assign page      = m_addr[23:16];
	assign io_page   = m_addr[17:10];

	always_comb
	begin
		bank_hot = 4'h0;
		cfg_idx  = 3'h0;
		off_chip = 1'b0;
		case (m_space)
			SP_MEM:
			begin
				if (page >= `EMP_BANK0_FIRST && page < bound_reg[7:0])
					bank_hot = 4'h1;
				else if (page >= bound_reg[7:0] && page < bound_reg[15:8])
					bank_hot = 4'h2;
				else if (page >= bound_reg[15:8] && page < bound_reg[23:16])
					bank_hot = 4'h4;
				else if (page >= bound_reg[23:16] && page <= bound_reg[31:24])
					bank_hot = 4'h8;
				off_chip = |bank_hot;
				cfg_idx  = {1'b0, bank_hot[3] | bank_hot[2], bank_hot[3] | bank_hot[1]};
			end
			SP_IO:
			begin
				off_chip = io_page >= `EMP_IO_FIRST_EXT;
				cfg_idx  = `EMP_IDX_IO;
			end
			SP_BOOT:
			begin
				off_chip = page < `EMP_BOOT_PAGES;
				cfg_idx  = `EMP_IDX_BOOT;
			end
			default:
			begin
				off_chip = 1'b0;
			end
		endcase
	end

	// packing: transfers per word and packed base address
	logic [`EMP_CFG_W-1:0] n_cfg;
	logic [1:0]            n_count;
	logic [19:0]           w_x2;
	logic [19:0]           n_base;

	assign n_cfg = cfg_reg[cfg_idx];
	assign w_x2  = {m_addr[18:0], 1'b0};

	always_comb
	begin
		if (n_cfg[`EMP_F_WIDE])
		begin
			n_count = m_w24 ? 2'd2 : 2'd1;
			n_base  = m_w24 ? w_x2 : m_addr[19:0];
		end
		else
		begin
			n_count = m_w24 ? 2'd3 : 2'd2;
			n_base  = m_w24 ? w_x2 + m_addr[19:0] : w_x2;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Access engine

	logic                  cur_core_reg, cur_we_reg, cur_w24_reg;
	logic [`EMP_CFG_W-1:0] cur_cfg_reg;
	logic [3:0]            cur_bank_reg;
	logic [1:0]            cur_space_reg;
	logic [19:0]           cur_base_reg;
	logic [23:0]           cur_wdata_reg;
	logic [23:0]           rbuf_reg;
	logic [1:0]            idx_reg, cnt_total_reg;
	logic [7:0]            str_cnt_reg;
	logic                  owns_bus;
	logic                  any_req;

	assign owns_bus = gr_st_reg == GR_OWN;
	assign any_req  = core_req | dma_live;

	logic [3:0] cur_wait;
	logic [7:0] str_len;
	assign cur_wait = cur_we_reg ? cur_cfg_reg[`EMP_F_WRWAIT] : cur_cfg_reg[`EMP_F_RDWAIT];
	assign str_len  = ({4'h0, cur_wait} << cur_cfg_reg[`EMP_F_CLKDIV])
		+ {6'h00, ctrl_reg[`EMP_F_RATIO]} + 8'h01;

	logic [15:0] wr_word;
	always_comb
	begin
		if (cur_cfg_reg[`EMP_F_WIDE])
			wr_word = (idx_reg == 2'd0) ? cur_wdata_reg[15:0] : {8'h00, cur_wdata_reg[23:16]};
		else
			wr_word = {8'h00, cur_wdata_reg[8*idx_reg +: 8]};
	end

	logic strobe_on;
	logic last_xfer;
	assign last_xfer = idx_reg + 2'd1 == cnt_total_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mem_st_reg    <= MEM_IDLE;
			cur_core_reg  <= 1'b0;
			cur_we_reg    <= 1'b0;
			cur_w24_reg   <= 1'b0;
			cur_cfg_reg   <= `EMP_CFG_RST;
			cur_bank_reg  <= 4'h0;
			cur_space_reg <= SP_MEM;
			cur_base_reg  <= 20'h00000;
			cur_wdata_reg <= 24'h000000;
			rbuf_reg      <= 24'h000000;
			idx_reg       <= 2'd0;
			cnt_total_reg <= 2'd1;
			str_cnt_reg   <= 8'h00;
			strobe_on     <= 1'b0;
			core_ack      <= 1'b0;
			core_err      <= 1'b0;
			dma_ack       <= 1'b0;
			dma_err       <= 1'b0;
			core_rdata    <= 24'h000000;
			dma_rdata     <= 24'h000000;
			ext_data_oe   <= 1'b0;
		end
		else
		begin
			core_ack <= 1'b0;
			core_err <= 1'b0;
			dma_ack  <= 1'b0;
			dma_err  <= 1'b0;
			case (mem_st_reg)
				MEM_IDLE:
				begin
					// wait while granted, resume on reclaim
					if (owns_bus && any_req && !core_ack && !dma_ack)
					begin
						cur_core_reg  <= pick_core;
						cur_we_reg    <= m_we;
						cur_w24_reg   <= m_w24;
						cur_cfg_reg   <= n_cfg;
						cur_bank_reg  <= bank_hot;
						cur_space_reg <= m_space;
						cur_base_reg  <= n_base;
						cur_wdata_reg <= pick_core ? core_wdata : dma_wdata;
						cnt_total_reg <= n_count;
						idx_reg       <= 2'd0;
						rbuf_reg      <= 24'h000000;
						if (off_chip)
							mem_st_reg <= MEM_SETUP;
						else
						begin
							// Off-chip decode miss: answered at once with error
							core_ack <= pick_core;
							core_err <= pick_core;
							dma_ack  <= pick_dma;
							dma_err  <= pick_dma;
						end
					end
				end
				MEM_SETUP:
				begin
					str_cnt_reg <= str_len;
					strobe_on   <= 1'b1;
					ext_data_oe <= cur_we_reg;
					mem_st_reg  <= MEM_STROBE;
				end
				MEM_STROBE:
				begin
					if (str_cnt_reg > 8'h01)
						str_cnt_reg <= str_cnt_reg - 8'h01;
					else if (cur_cfg_reg[`EMP_F_ACKMODE] && !rdy_s2_reg)
						mem_st_reg <= MEM_ACKW;
					else
						mem_st_reg <= MEM_HOLD;
				end
				MEM_ACKW:
				begin
					if (rdy_s2_reg)
						mem_st_reg <= MEM_HOLD;
				end
				MEM_HOLD:
				begin
					if (strobe_on && !cur_we_reg)
					begin
						if (cur_cfg_reg[`EMP_F_WIDE] && idx_reg == 2'd0)
							rbuf_reg[15:0] <= data_s2_reg;
						else if (cur_cfg_reg[`EMP_F_WIDE])
							rbuf_reg[23:16] <= data_s2_reg[7:0];
						else
							rbuf_reg[8*idx_reg +: 8] <= data_s2_reg[7:0];
					end
					strobe_on <= 1'b0;
					// Write hold extension keeps data one cycle past the strobe
					if (strobe_on && cur_we_reg && cur_cfg_reg[`EMP_F_HOLDEXT])
						mem_st_reg <= MEM_HOLD;
					else
					begin
						ext_data_oe <= 1'b0;
						if (last_xfer)
							mem_st_reg <= MEM_DONE;
						else
						begin
							idx_reg    <= idx_reg + 2'd1;
							mem_st_reg <= MEM_SETUP;
						end
					end
				end
				MEM_DONE:
				begin
					core_ack   <= cur_core_reg;
					dma_ack    <= ~cur_core_reg;
					core_rdata <= cur_core_reg ? rbuf_reg : core_rdata;
					dma_rdata  <= cur_core_reg ? dma_rdata : rbuf_reg;
					mem_st_reg <= MEM_IDLE;
				end
				default:
				begin
					mem_st_reg <= MEM_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lock_reg <= 1'b0;
		else if (mem_st_reg == MEM_DONE && cur_core_reg)
			lock_reg <= ~cur_we_reg & core_lock & ~lock_reg;
	end

	// Pin drivers, selects inactive outside an access
	logic in_xfer;
	assign in_xfer = mem_st_reg != MEM_IDLE && mem_st_reg != MEM_DONE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_addr_o          <= 20'h00000;
			ext_data_o          <= 16'h0000;
			bank_select_n       <= 4'hF;
			io_space_select_n   <= 1'b1;
			boot_space_select_n <= 1'b1;
			ext_rd_strobe       <= 1'b1;
			ext_wr_strobe       <= 1'b1;
		end
		else
		begin
			ext_addr_o <= cur_base_reg + {18'h00000, idx_reg};
			ext_data_o <= wr_word;
			bank_select_n       <= ~(cur_bank_reg & {4{in_xfer && cur_space_reg == SP_MEM}});
			io_space_select_n   <= ~(in_xfer && cur_space_reg == SP_IO);
			boot_space_select_n <= ~(in_xfer && cur_space_reg == SP_BOOT);
			// strobe polarity
			// Active-low by default: idle level must match the reset value
			ext_rd_strobe <= cur_cfg_reg[`EMP_F_POLHIGH] ^ (~strobe_on | cur_we_reg);
			ext_wr_strobe <= cur_cfg_reg[`EMP_F_POLHIGH] ^ (~strobe_on | ~cur_we_reg);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Bus request and grant

	// reset only settles the handshake when no request is pending
	always_ff @(posedge aclk)
	begin
		if (!aresetn && !breq_s2_reg)
		begin
			gr_st_reg        <= GR_OWN;
			ext_bus_grant_n  <= 1'b1;
			ext_addr_oe      <= 1'b1;
			ext_ctl_oe       <= 1'b1;
		end
		else
		begin
			case (gr_st_reg)
				GR_OWN:
				begin
					// lowest priority, after two sync stages
					if (breq_s2_reg && mem_st_reg == MEM_IDLE && !any_req
						&& (!lock_reg || !aresetn))
					begin
						ext_addr_oe <= 1'b0;
						ext_ctl_oe  <= 1'b0;
						gr_st_reg   <= GR_FLOAT;
					end
				end
				GR_FLOAT:
				begin
					ext_bus_grant_n <= 1'b0;
					gr_st_reg       <= GR_GIVEN;
				end
				GR_GIVEN:
				begin
					if (!breq_s2_reg)
					begin
						ext_bus_grant_n <= 1'b1;
						gr_st_reg       <= GR_RECLAIM;
					end
				end
				GR_RECLAIM:
				begin
					ext_addr_oe <= 1'b1;
					ext_ctl_oe  <= 1'b1;
					gr_st_reg   <= GR_OWN;
				end
				default:
				begin
					gr_st_reg <= GR_OWN;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_stall       <= 1'b0;
			grant_held_off_n <= 1'b1;
		end
		else
		begin
			core_stall       <= core_req & ~owns_bus;
			grant_held_off_n <= ~(any_req & ~owns_bus);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite register slave

	logic        aw_have_reg, w_have_reg;
	logic [7:0]  awaddr_q_reg;
	logic [31:0] wdata_q_reg;
	logic [3:0]  wstrb_q_reg;
	logic        wr_fire, aw_have_next, w_have_next;

	assign wr_fire      = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	assign aw_have_next = (s_axi_awvalid & s_axi_awready) | (aw_have_reg & ~wr_fire);
	assign w_have_next  = (s_axi_wvalid & s_axi_wready) | (w_have_reg & ~wr_fire);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	logic [31:0] wr_merged;
	logic        wr_cfg_hit;
	logic [2:0]  wr_cfg_idx;
	assign wr_cfg_idx = awaddr_q_reg[4:2];
	assign wr_cfg_hit = awaddr_q_reg[1:0] == 2'b00 && awaddr_q_reg <= `EMP_OFS_CFG_LAST;

	always_comb
	begin
		if (wr_cfg_hit)
			wr_merged = merge({18'h00000, cfg_reg[wr_cfg_idx]}, wdata_q_reg, wstrb_q_reg);
		else if (awaddr_q_reg == `EMP_OFS_BOUND)
			wr_merged = merge(bound_reg, wdata_q_reg, wstrb_q_reg);
		else
			wr_merged = merge({29'h00000000, ctrl_reg}, wdata_q_reg, wstrb_q_reg);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			awaddr_q_reg  <= 8'h00;
			wdata_q_reg   <= 32'h00000000;
			wstrb_q_reg   <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end
		else
		begin
			aw_have_reg   <= aw_have_next;
			w_have_reg    <= w_have_next;
			s_axi_awready <= ~aw_have_next;
			s_axi_wready  <= ~w_have_next;
			if (s_axi_awvalid && s_axi_awready)
				awaddr_q_reg <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q_reg <= s_axi_wdata;
				wstrb_q_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_cfg_hit || awaddr_q_reg == `EMP_OFS_BOUND
					|| awaddr_q_reg == `EMP_OFS_CTRL) ? 2'b00 : 2'b10;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 6; i++)
				cfg_reg[i] <= `EMP_CFG_RST;
			bound_reg <= `EMP_BOUND_RST;
			ctrl_reg  <= `EMP_CTRL_RST;
		end
		else if (wr_fire)
		begin
			if (wr_cfg_hit)
				cfg_reg[wr_cfg_idx] <= wr_merged[`EMP_CFG_W-1:0];
			else if (awaddr_q_reg == `EMP_OFS_BOUND)
				bound_reg <= wr_merged;
			else if (awaddr_q_reg == `EMP_OFS_CTRL)
				ctrl_reg <= wr_merged[2:0];
		end
	end

	logic [31:0] rd_word;
	logic        rd_ok;
	always_comb
	begin
		rd_ok   = 1'b1;
		rd_word = 32'h00000000;
		if (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= `EMP_OFS_CFG_LAST)
			rd_word = {18'h00000, cfg_reg[s_axi_araddr[4:2]]};
		else if (s_axi_araddr == `EMP_OFS_BOUND)
			rd_word = bound_reg;
		else if (s_axi_araddr == `EMP_OFS_CTRL)
			rd_word = {29'h00000000, ctrl_reg};
		else if (s_axi_araddr == `EMP_OFS_STAT)
			rd_word = {27'h0000000, lock_reg, in_xfer, ~grant_held_off_n,
				~ext_bus_grant_n, breq_s2_reg};
		else
			rd_ok = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // emp_ext_mem_unit

`default_nettype wire

// [pkg/emp_consts.svh]
// Constants of the external memory port: register offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a 125 MHz peripheral clock.
//
// Notes on behaviour
// - Each off-chip space has its own wait, mode, divide, hold, polarity, width set.
// - Each off-chip space selects an 8-bit or 16-bit external data path.
// - 16-bit data, 20-bit address; packing fetches 16- or 24-bit words on any width.
// - Four banks sized in 64K-word pages, each with its own active-low select.
// - Reset boundaries: bank0 pages 1-63, bank1 64-127, bank2 128-191, bank3 192-254.
// - I/O space: 256 pages of 1024; pages 0-31 on-chip, 32-255 assert I/O select.
// - Boot space is one off-chip bank of 254 pages with its own select.
// - Core and DMA peripherals both request external access; the unit arbitrates.
// - External bus request has lowest priority; granted only with no internal request.
// - Grant follows request by at least three peripheral clock cycles.
// - On granting, float address, data, selects and strobes, then assert grant.
// - While granted away, external core accesses stall.
// - No grant between two external reads of one instruction; allowed read-to-write.
// - Request released: drop grant, drive bus again, resume stalled access.
// - The request/grant handshake works always, also while reset is asserted.
// - Held-off output asserts when an access is ready but the bus is granted away.
// - A configuration option reserves the interface for the core alone.
// - Strobe widths depend on the core to peripheral clock ratio.
`ifndef EMP_CONSTS_SVH
`define EMP_CONSTS_SVH

// Register byte offsets
`define EMP_OFS_CFG0      8'h00
`define EMP_OFS_CFG_LAST  8'h14
`define EMP_OFS_BOUND     8'h18
`define EMP_OFS_CTRL      8'h1C
`define EMP_OFS_STAT      8'h20

// Access-parameter fields
`define EMP_F_RDWAIT      3:0
`define EMP_F_WRWAIT      7:4
`define EMP_F_ACKMODE     8
`define EMP_F_CLKDIV      10:9
`define EMP_F_HOLDEXT     11
`define EMP_F_POLHIGH     12
`define EMP_F_WIDE        13
`define EMP_CFG_W         14
`define EMP_CFG_RST       14'h2033

// Control fields
`define EMP_F_EXCL        0
`define EMP_F_RATIO       2:1
`define EMP_CTRL_RST      3'h0

// Bank boundaries, start pages of banks 1..3 and last page of bank 3
`define EMP_BOUND_RST     32'hFEC08040
`define EMP_BANK0_FIRST   8'h01
`define EMP_IO_FIRST_EXT  8'h20
`define EMP_BOOT_PAGES    8'hFE

// Space indices into the parameter sets
`define EMP_IDX_IO        3'h4
`define EMP_IDX_BOOT      3'h5

`endif

// [pkg/emp_pkg.sv]
// Types of the external memory port.
// Assumes the constants header is compiled alongside.
`default_nettype none

package emp_pkg;

	typedef enum logic [2:0]
	{
		MEM_IDLE   = 3'b000,
		MEM_SETUP  = 3'b001,
		MEM_STROBE = 3'b010,
		MEM_ACKW   = 3'b011,
		MEM_HOLD   = 3'b100,
		MEM_DONE   = 3'b101
	} emp_mem_st_t;

	typedef enum logic [1:0]
	{
		GR_OWN     = 2'b00,
		GR_FLOAT   = 2'b01,
		GR_GIVEN   = 2'b10,
		GR_RECLAIM = 2'b11
	} emp_gr_st_t;

	typedef enum logic [1:0]
	{
		SP_MEM  = 2'b00,
		SP_IO   = 2'b01,
		SP_BOOT = 2'b10
	} emp_space_t;

endpackage : emp_pkg

`default_nettype wire

// [bench/emp_assertions.sv]
// Checker for the external port pins and the bus grant handshake.
// Assumes it is bound to emp_ext_mem_unit.
`default_nettype none
module emp_assertions
(
	// Watched ports
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic	core_req,
	input wire logic	core_ack,
	input wire logic	core_err,
	input wire logic	core_stall,
	input wire logic	ext_addr_oe,
	input wire logic	ext_data_oe,
	input wire logic	ext_ctl_oe,
	input wire logic [3:0]	bank_select_n,
	input wire logic	io_space_select_n,
	input wire logic	boot_space_select_n,
	input wire logic	ext_bus_req_n,
	input wire logic	ext_bus_grant_n,
	input wire logic	grant_held_off_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_float_on_grant: assert property (!ext_bus_grant_n |-> !ext_addr_oe && !ext_data_oe && !ext_ctl_oe)
		else $error("pins driven while granted");
	a_grant_latency: assert property ($fell(ext_bus_grant_n) |-> !$past(ext_bus_req_n, 3))
		else $error("grant too early");
	a_internal_first: assert property ($fell(ext_bus_grant_n) |-> !$past(core_req))
		else $error("grant over pending core request");
	a_stall_given: assert property ((core_req && !ext_bus_grant_n)[*2] |-> core_stall)
		else $error("core not stalled");
	a_held_off: assert property ((core_req && !ext_bus_grant_n)[*3] |-> !grant_held_off_n)
		else $error("held off not shown");
	a_one_select: assert property ($onehot0(~{bank_select_n, io_space_select_n, boot_space_select_n}))
		else $error("two selects active");
	a_err_with_ack: assert property (core_err |-> core_ack)
		else $error("error without ack");
	// Also checked in reset, the handshake must keep working there
	a_grant_release: assert property (disable iff (1'b0) ext_bus_req_n[*5] |-> ext_bus_grant_n)
		else $error("grant kept after release");
endmodule // emp_assertions
bind emp_ext_mem_unit emp_assertions i_emp_assertions
(
	.aclk(aclk), .aresetn(aresetn), .core_req(core_req), .core_ack(core_ack),
	.core_err(core_err), .core_stall(core_stall), .ext_addr_oe(ext_addr_oe),
	.ext_data_oe(ext_data_oe), .ext_ctl_oe(ext_ctl_oe), .bank_select_n(bank_select_n),
	.io_space_select_n(io_space_select_n), .boot_space_select_n(boot_space_select_n),
	.ext_bus_req_n(ext_bus_req_n), .ext_bus_grant_n(ext_bus_grant_n),
	.grant_held_off_n(grant_held_off_n)
);
`default_nettype wire

// [bench/emp_ext_model.sv]
// Off-chip memory: 256 words keyed by the low address byte.
// Assumes active-low strobes; any select enables it.
`default_nettype none
module emp_ext_model
(
	// Pins from the port
	input wire logic	aclk,
	input wire logic [19:0]	addr,
	input wire logic [15:0]	dout,
	input wire logic	dout_oe,
	input wire logic	ctl_oe,
	input wire logic [5:0]	sel_n,
	input wire logic	rd_n,
	input wire logic	wr_n,
	// Pins to the port
	output logic [15:0]	din
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0]	mem [256];
	logic [15:0]	last = 16'h0;
	logic		sel;
	assign sel = ctl_oe && !(&sel_n);
	// Idle bus toggles so a stale value never reads as good data
	assign din = (sel && !rd_n) ? mem[addr[7:0]] : ~last;
	always_ff @(posedge aclk)
	begin
		last <= din;
		if (sel && !wr_n && dout_oe)
			mem[addr[7:0]] <= dout;
	end
endmodule // emp_ext_model
`default_nettype wire

// [bench/tb.sv]
// Bench: registers, off-chip traffic in all spaces and widths, bus grant.
// Assumes checker and off-chip model compiled first.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic		aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic		arvalid = 1'h0, rready = 1'h0, req_c = 1'h0, req_d = 1'h0;
	logic		we = 1'h0, w24 = 1'h0, brq_n = 1'h1, lk = 1'h0, dm;
	logic [7:0]	awaddr = 8'h0, araddr = 8'h0;
	logic [31:0]	wdata = 32'h0, rdata;
	logic [1:0]	sp = 2'h0, bresp, rresp;
	logic [23:0]	ad = 24'h0, wd = 24'h0, c_rd, d_rd;
	logic		awr, wr, bv, arr, rv, c_ack, c_err, c_st, d_ack, d_err, aoe, doe, coe;
	logic		rs_n, ws_n, ion, bon, gnt_n, hold_n;
	logic [19:0]	xa;
	logic [15:0]	xo, xi;
	logic [3:0]	bsn;
	logic [26:0]	ce, cq [$];
	logic [34:0]	re, rq [$];
	int		bad_count = 0, tests_run = 0, k, s, w, n;
	always #4 aclk = ~aclk;
	emp_ext_mem_unit i_emp_ext_mem_unit
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
		.core_req(req_c), .core_we(we), .core_space(sp), .core_addr(ad), .core_wdata(wd),
		.core_w24(w24), .core_lock(lk), .core_ack(c_ack), .core_err(c_err),
		.core_rdata(c_rd), .core_stall(c_st), .dma_req(req_d), .dma_we(we), .dma_space(sp),
		.dma_addr(ad), .dma_wdata(wd), .dma_w24(w24), .dma_ack(d_ack), .dma_err(d_err),
		.dma_rdata(d_rd), .ext_addr_o(xa), .ext_addr_oe(aoe), .ext_data_o(xo),
		.ext_data_oe(doe), .ext_data_i(xi), .bank_select_n(bsn), .io_space_select_n(ion),
		.boot_space_select_n(bon), .ext_rd_strobe(rs_n), .ext_wr_strobe(ws_n),
		.ext_ctl_oe(coe), .ext_ready_i(1'h1), .ext_bus_req_n(brq_n),
		.ext_bus_grant_n(gnt_n), .grant_held_off_n(hold_n)
	);
	emp_ext_model i_emp_ext_model
	(
		.aclk(aclk), .addr(xa), .dout(xo), .dout_oe(doe), .ctl_oe(coe),
		.sel_n({bsn, ion, bon}), .rd_n(rs_n), .wr_n(ws_n), .din(xi)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		complete_run();
	endtask
	// Each bus task lets one edge pass so a strobe is never set twice in a step
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (i = 0; i < 99; i++)
		begin
			@(posedge aclk);
			if (awr)
				awvalid <= 1'h0;
			if (wr)
				wvalid <= 1'h0;
			if (bv)
				break;
		end
		chk("bresp", bresp, 2'h0);
		bready <= 1'h0;
		if (i == 99)
			hang();
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, input logic [34:0] e);
		int i;
		rq.push_back(e);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (i = 0; i < 99; i++)
		begin
			@(posedge aclk);
			if (arr)
				arvalid <= 1'h0;
			if (rv)
				break;
		end
		rready <= 1'h0;
		if (i == 99)
			hang();
		@(posedge aclk);
	endtask
	// Note fields: read check, 24-bit word, error, data
	task automatic acc(input logic d, input logic [26:0] e);
		int i;
		cq.push_back(e);
		req_c <= !d;
		req_d <= d;
		for (i = 0; i < 400; i++)
		begin
			@(posedge aclk);
			if (c_ack || d_ack)
				break;
		end
		req_c <= 1'h0;
		req_d <= 1'h0;
		if (i == 400)
			hang();
		@(posedge aclk);
	endtask
	task automatic wait_grant(input logic lvl);
		for (n = 0; n < 60 && gnt_n !== lvl; n++)
			@(posedge aclk);
		if (n == 60)
			hang();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk)
	begin
		if (c_ack || d_ack)
		begin
			ce = cq.pop_front();
			chk("ack err", c_ack ? c_err : d_err, ce[24]);
			if (ce[26])
				chk("rdata", ce[25] ? (c_ack ? c_rd : d_rd) : (c_ack ? c_rd[15:0] : d_rd[15:0]), ce[25] ? ce[23:0] : ce[15:0]);
		end
		if (rv && rready)
		begin
			re = rq.pop_front();
			chk("rresp", rresp, re[33:32]);
			if (re[34])
				chk("reg", rdata, re[31:0]);
		end
	end
	initial
	begin
		void'($urandom(74));
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		axr(8'h00, {3'h4, 32'h00002033});
		axr(8'h14, {3'h4, 32'h00002033});
		axr(8'h18, {3'h4, 32'hFEC08040});
		axr(8'h40, {3'h2, 32'h0});
		for (k = 0; k < 2; k++)
		begin
			for (s = 0; s < 3; s++)
				axw(s ? 8'h0C + 8'(4 * s) : 8'h00, k ? 32'h00000033 : 32'h00002033);
			for (s = 0; s < 6; s++)
			begin
				w = s % 2;
				dm = 1'($urandom);
				sp <= 2'(s / 2);
				ad <= (s < 2 ? 24'h010000 : s < 4 ? 24'h008000 : 24'h000000) | 24'($urandom % 64);
				wd <= 24'($urandom);
				w24 <= 1'(w);
				we <= 1'h1;
				acc(dm, {2'h0, 1'h0, 24'h0});
				we <= 1'h0;
				acc(dm, {1'h1, 1'(w), 1'h0, wd});
			end
		end
		sp <= 2'h1;
		ad <= 24'h001400;
		acc(1'h0, {3'h1, 24'h0});
		brq_n <= 1'h0;
		wait_grant(1'h0);
		chk("grant delay", n >= 3, 1'h1);
		sp <= 2'h0;
		ad <= 24'h010005;
		we <= 1'h1;
		fork
			acc(1'h0, {3'h0, 24'h0});
			begin
				repeat (8) @(posedge aclk);
				chk("stall", {c_st, hold_n}, 2'h2);
				brq_n <= 1'h1;
			end
		join
		// A locked read keeps the bus until the next core access completes
		lk <= 1'h1;
		we <= 1'h0;
		acc(1'h0, {3'h0, 24'h0});
		lk <= 1'h0;
		brq_n <= 1'h0;
		repeat (6) @(posedge aclk);
		chk("lock", gnt_n, 1'h1);
		acc(1'h0, {3'h0, 24'h0});
		wait_grant(1'h0);
		brq_n <= 1'h1;
		wait_grant(1'h1);
		aresetn <= 1'h0;
		brq_n <= 1'h0;
		wait_grant(1'h0);
		chk("reset grant", gnt_n, 1'h0);
		brq_n <= 1'h1;
		wait_grant(1'h1);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		complete_run();
	end
endmodule // tb
`default_nettype wire
